// File: logic/cocr_pkg.sv
// constants, types and helpers shared by the clock output control bank
// assumes a byte-level serial front end outside this block
package cocr_pkg;

    localparam int NUM_REGS = 6;
    localparam int REG_W = 8;

    // register offsets as carried in the command code
    localparam logic [6:0] OFS_DIFF_OUTPUT_ENABLE_A = 7'h00;
    localparam logic [6:0] OFS_OUTPUT_ENABLE_SPREAD_CTRL = 7'h01;
    localparam logic [6:0] OFS_BUS_CLOCK_ENABLE = 7'h02;
    localparam logic [6:0] OFS_DIFF_STOP_SELECT = 7'h03;
    localparam logic [6:0] OFS_FREE_CLOCK_STOP_SELECT = 7'h04;
    localparam logic [6:0] OFS_STOP_POWERDOWN_DRIVE_MODE = 7'h05;

    // power-up values, offset 0 in the low byte
    localparam logic [NUM_REGS-1:0][7:0] RST_BANK =
        {8'h00, 8'h07, 8'h00, 8'hff, 8'hf6, 8'hff};
    // writable bits; the rest are reserved and hold their power-up value
    localparam logic [NUM_REGS-1:0][7:0] WMASK_BANK =
        {8'h8f, 8'h78, 8'hfe, 8'hff, 8'hff, 8'hfe};

    // command code layout
    localparam int CMD_BYTE_MODE_BIT = 7;
    // byte count sent ahead of block read data
    localparam logic [7:0] BLOCK_COUNT = 8'h06;

    // field positions
    localparam int F0_DIFF_OE_LSB = 1;
    localparam int F1_FREE0_OE = 7;
    localparam int F1_DISP_OE = 6;
    localparam int F1_USB_OE = 5;
    localparam int F1_XTAL_OE = 4;
    localparam int F1_SPREAD_CENTER = 3;
    localparam int F1_CPU_OE_LSB = 1;
    localparam int F1_SPREAD_EN = 0;
    localparam int F2_PCI_OE_LSB = 2;
    localparam int F2_FREE1_OE = 0;
    localparam int F3_DIFF_STOP_LSB = 1;
    localparam int F4_DISP_PD_HIZ = 6;
    localparam int F4_FREE_STOP_LSB = 3;
    localparam int F5_STOP_HIZ = 7;
    localparam int F5_DIFF_PD_HIZ = 3;
    localparam int F5_CPU_PD_HIZ_LSB = 0;

    // gate vector widths
    localparam int DIFF_GATES = 10;
    localparam int BUS_GATES = 9;

    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_BYTE = 2'b01,
        CMD_BLOCK_CNT = 2'b10,
        CMD_BLOCK_DATA = 2'b11
    } cocr_cmd_state_t;

    typedef logic [NUM_REGS-1:0][7:0] cocr_bank_t;

    function automatic logic cocr_idx_ok(input logic [6:0] idx);
        return idx < 7'(NUM_REGS);
    endfunction

    // value stored for a write: reserved bits keep their fixed value
    function automatic logic [7:0] cocr_store(input logic [6:0] idx,
                                              input logic [7:0] data);
        logic [7:0] m;
        m = 8'h00;
        if (cocr_idx_ok(idx)) begin
            m = WMASK_BANK[idx[2:0]];
            return (data & m) | (RST_BANK[idx[2:0]] & ~m);
        end
        return 8'h00;
    endfunction

endpackage

// File: logic/cocr_if.sv
// carriers between the bank top and its command decoder and output gates
// assumes all parties share clk_i and arst_n_i
`timescale 1ns/1ps
`default_nettype none

interface cocr_acc_if;
    logic wr_stb;
    logic [6:0] wr_idx;
    logic [7:0] wr_data;
    logic rd_stb;
    logic rd_count;
    logic [6:0] rd_idx;
    logic commit;
    modport cmd (output wr_stb, wr_idx, wr_data, rd_stb, rd_count, rd_idx,
                 commit);
    modport bank (input wr_stb, wr_idx, wr_data, rd_stb, rd_count, rd_idx,
                  commit);
endinterface

interface cocr_gate_if #(parameter int N = 1);
    logic [N-1:0] want;
    logic phase_low;
    logic [N-1:0] run;
    modport ctl (output want, phase_low, input run);
    modport gate (input want, phase_low, output run);
endinterface

`default_nettype wire

// File: logic/cocr_cmd.sv
// command code decoder: turns serial bytes into bank accesses
// assumes the front end flags the command byte and the end of transfer
`timescale 1ns/1ps
`default_nettype none

module cocr_cmd
    import cocr_pkg::*;
(
    input wire logic clk_i,        // system clock
    input wire logic arst_n_i,     // async reset, active low
    input wire logic byte_valid_i, // written byte present
    input wire logic cmd_first_i,  // this byte is the command code
    input wire logic [7:0] byte_i, // written byte
    input wire logic rd_req_i,     // front end wants a read byte
    input wire logic xfer_end_i,   // stop seen
    cocr_acc_if.cmd acc            // bank access
);

    cocr_cmd_state_t state_r, state_nxt;
    logic [6:0] ptr_r, ptr_nxt;
    logic step;

    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        acc.wr_stb = 1'b0;
        acc.rd_stb = 1'b0;
        acc.rd_count = 1'b0;
        step = 1'b0;
        if (byte_valid_i && cmd_first_i) begin
            if (byte_i[CMD_BYTE_MODE_BIT]) begin
                state_nxt = CMD_BYTE;
                ptr_nxt = byte_i[6:0];
            end else begin
                state_nxt = CMD_BLOCK_CNT;
                ptr_nxt = 7'h00;
            end
        end else if (byte_valid_i) begin
            unique case (state_r)
                CMD_IDLE: ;
                CMD_BLOCK_CNT: state_nxt = CMD_BLOCK_DATA;
                CMD_BYTE, CMD_BLOCK_DATA: begin
                    acc.wr_stb = 1'b1;
                    step = 1'b1;
                end
            endcase
        end else if (rd_req_i) begin
            unique case (state_r)
                CMD_IDLE: ;
                CMD_BLOCK_CNT: begin
                    acc.rd_count = 1'b1;
                    state_nxt = CMD_BLOCK_DATA;
                end
                CMD_BYTE, CMD_BLOCK_DATA: begin
                    acc.rd_stb = 1'b1;
                    step = 1'b1;
                end
            endcase
        end
        // pointer saturates so a long block cannot wrap onto offset 0
        if (step && ptr_r != 7'h7f) begin
            ptr_nxt = ptr_r + 7'h01;
        end
        if (xfer_end_i) begin
            state_nxt = CMD_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= CMD_IDLE;
            ptr_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    assign acc.wr_idx = ptr_r;
    assign acc.wr_data = byte_i;
    assign acc.rd_idx = ptr_r;
    assign acc.commit = xfer_end_i;

    chk_cmd_byte_sel: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        byte_valid_i && cmd_first_i && byte_i[7] && !xfer_end_i
        |=> state_r == CMD_BYTE && ptr_r == $past(byte_i[6:0]))
        else $error("byte command did not load the offset");

    chk_cmd_block_zero: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        byte_valid_i && cmd_first_i && !byte_i[7] && !xfer_end_i
        |=> state_r == CMD_BLOCK_CNT && ptr_r == 7'h00)
        else $error("block command did not start at offset zero");

endmodule

`default_nettype wire

// File: logic/cocr_gate.sv
// glitch-free run gates for one group of clock outputs
// assumes phase_low marks cycles where the group's clock sits low
`timescale 1ns/1ps
`default_nettype none

module cocr_gate #(
    parameter int N = 1
) (
    input wire logic clk_i,    // system clock
    input wire logic arst_n_i, // async reset, active low
    cocr_gate_if.gate g        // want in, run out
);

    logic [N-1:0] run_r, run_nxt;

    generate
        for (genvar i = 0; i < N; i++) begin : g_bit
            always_comb begin
                run_nxt[i] = g.phase_low ? g.want[i] : run_r[i];
            end
        end
    endgenerate

    // gates start closed and open at the first low phase, so no runt pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_r <= '0;
        end else begin
            run_r <= run_nxt;
        end
    end

    assign g.run = run_r;

    chk_gate_hold_high: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !g.phase_low |=> $stable(run_r))
        else $error("run gate changed outside the low phase");

    chk_gate_follow_want: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        g.phase_low |=> run_r == $past(g.want))
        else $error("run gate missed its request in the low phase");

endmodule

`default_nettype wire

// File: logic/cocr_top.sv
// clock output control bank: six control bytes and the output gating
// assumes a serial front end delivering decoded bytes and synchronous
// stop, power-down and phase inputs
//
// Notes on behaviour
// - reg0 bits 7:1 enable peripheral pairs
// - reg1 bits 2:1 enable cpu pairs
// - reg1 bit 6 enables display pair
// - single-ended enables in reg1 and reg2
// - reg1 bit 3 picks spread profile
// - reg1 bit 0 turns spread on
// - reg3 marks peripheral pairs stoppable
// - reg4 bits 5:3 mark free-running bus clocks stoppable
// - reg4 bit 6 tristates display in power-down
// - reg5 bit 7 tristates stopped peripheral pairs
// - reg5 bit 3 peripheral power-down tristate
// - reg5 bits 2:0 cpu power-down tristate
// - registers come up at their defaults
// - command bit 7 picks byte or block
// - stops and restarts without short pulses
// - power-down drives clocks low first
`timescale 1ns/1ps
`default_nettype none

module cocr_top
    import cocr_pkg::*;
(
    input wire logic clk_i,              // system clock, 100 MHz
    input wire logic arst_n_i,           // async reset, active low
    input wire logic byte_valid_i,       // written byte present
    input wire logic cmd_first_i,        // byte is the command code
    input wire logic [7:0] byte_i,       // written byte
    input wire logic rd_req_i,           // read byte wanted
    input wire logic xfer_end_i,         // stop seen on the bus
    input wire logic bus_clock_stop_i,   // software stop asserted
    input wire logic power_down_i,       // power-down input asserted
    input wire logic debug_port_mode_i,  // pair 7 is debug-port cpu pair
    input wire logic diff_phase_low_i,   // differential clocks low
    input wire logic bus_phase_low_i,    // bus clocks low
    output logic [7:0] rd_data_o,        // read byte
    output logic rd_valid_o,             // read byte strobe
    output logic [7:1] periph_run_o,     // peripheral pair toggling
    output logic [7:1] periph_oe_o,      // peripheral pair driven
    output logic [1:0] cpu_run_o,        // cpu pair toggling
    output logic [1:0] cpu_oe_o,         // cpu pair driven
    output logic disp_run_o,             // display pair toggling
    output logic disp_oe_o,              // display pair driven
    output logic [2:0] free_run_o,       // free-running bus clocks toggling
    output logic [2:0] free_oe_o,        // free-running bus clocks driven
    output logic [5:0] pci_run_o,        // bus clocks toggling
    output logic [5:0] pci_oe_o,         // bus clocks driven
    output logic usb_oe_o,               // 48 MHz clock driven
    output logic xtal_oe_o,              // crystal copy driven
    output logic spread_en_o,            // spread spectrum on
    output logic spread_center_o         // centre spread selected
);

    cocr_acc_if acc ();
    cocr_gate_if #(.N(DIFF_GATES)) dg ();
    cocr_gate_if #(.N(BUS_GATES)) bg ();

    cocr_cmd u_cmd (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .byte_valid_i(byte_valid_i),
        .cmd_first_i(cmd_first_i),
        .byte_i(byte_i),
        .rd_req_i(rd_req_i),
        .xfer_end_i(xfer_end_i),
        .acc(acc.cmd)
    );

    cocr_gate #(.N(DIFF_GATES)) u_diff_gate (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .g(dg.gate)
    );

    cocr_gate #(.N(BUS_GATES)) u_bus_gate (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .g(bg.gate)
    );

    // register bank
    cocr_bank_t shadow_r, shadow_nxt;
    cocr_bank_t act_r, act_nxt;
    logic touched_r, touched_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;

    always_comb begin
        shadow_nxt = shadow_r;
        act_nxt = act_r;
        touched_nxt = touched_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        // reserved bits forced back to fixed values
        if (acc.wr_stb && cocr_idx_ok(acc.wr_idx)) begin
            shadow_nxt[acc.wr_idx[2:0]] = cocr_store(acc.wr_idx, acc.wr_data);
        end
        // applied only once the write completes
        if (acc.commit) begin
            act_nxt = shadow_nxt;
            touched_nxt = 1'b1;
        end
        if (acc.rd_count) begin
            rd_data_nxt = BLOCK_COUNT;
            rd_valid_nxt = 1'b1;
        end else if (acc.rd_stb) begin
            rd_data_nxt = cocr_idx_ok(acc.rd_idx) ?
                          act_r[acc.rd_idx[2:0]] : 8'h00;
            rd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shadow_r <= RST_BANK;
            act_r <= RST_BANK;
            touched_r <= 1'b0;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            shadow_r <= shadow_nxt;
            act_r <= act_nxt;
            touched_r <= touched_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // output control
    logic [7:0] r0, r1, r2, r3, r4, r5;
    logic [7:1] p_en, p_stop, p_pdhiz, p_oe_nxt;
    logic [7:1] periph_oe_r;
    logic [1:0] cpu_oe_r, cpu_oe_nxt;
    logic disp_oe_r, disp_oe_nxt;
    logic [2:0] free_en, free_stop;
    logic [2:0] free_oe_r;
    logic [5:0] pci_oe_r;
    logic usb_oe_r, xtal_oe_r, spread_en_r, spread_center_r;

    assign r0 = act_r[OFS_DIFF_OUTPUT_ENABLE_A[2:0]];
    assign r1 = act_r[OFS_OUTPUT_ENABLE_SPREAD_CTRL[2:0]];
    assign r2 = act_r[OFS_BUS_CLOCK_ENABLE[2:0]];
    assign r3 = act_r[OFS_DIFF_STOP_SELECT[2:0]];
    assign r4 = act_r[OFS_FREE_CLOCK_STOP_SELECT[2:0]];
    assign r5 = act_r[OFS_STOP_POWERDOWN_DRIVE_MODE[2:0]];

    assign dg.phase_low = diff_phase_low_i;
    assign bg.phase_low = bus_phase_low_i;

    // one enable drives true and complement pins of a pair alike
    generate
        for (genvar k = 1; k <= 7; k++) begin : g_periph
            always_comb begin
                p_en[k] = r0[F0_DIFF_OE_LSB + k - 1];
                // stoppable unless pair 7 serves the debug port
                p_stop[k] = bus_clock_stop_i &&
                            r3[F3_DIFF_STOP_LSB + k - 1] &&
                            !(k == 7 && debug_port_mode_i);
                p_pdhiz[k] = (k == 7 && debug_port_mode_i) ?
                             r5[F5_CPU_PD_HIZ_LSB + 2] : r5[F5_DIFF_PD_HIZ];
                // driven low before being released to high impedance
                dg.want[k-1] = p_en[k] && !power_down_i && !p_stop[k];
                // stopped pairs tristate once halted low
                p_oe_nxt[k] = p_en[k] &&
                    !((((power_down_i && p_pdhiz[k]) ||
                        (p_stop[k] && r5[F5_STOP_HIZ]))) && !dg.run[k-1]);
            end
        end
    endgenerate

    // one process per pair so each want bit keeps a single owner
    generate
        for (genvar j = 0; j < 2; j++) begin : g_cpu
            always_comb begin
                dg.want[7+j] = r1[F1_CPU_OE_LSB + j] && !power_down_i;
                cpu_oe_nxt[j] = r1[F1_CPU_OE_LSB + j] &&
                    !(power_down_i && r5[F5_CPU_PD_HIZ_LSB + j] &&
                      !dg.run[7+j]);
            end
        end
    endgenerate

    always_comb begin
        dg.want[9] = r1[F1_DISP_OE] && !power_down_i;
        disp_oe_nxt = r1[F1_DISP_OE] &&
            !(power_down_i && r4[F4_DISP_PD_HIZ] && !dg.run[9]);
    end

    always_comb begin
        free_en = {r2[F2_FREE1_OE + 1], r2[F2_FREE1_OE], r1[F1_FREE0_OE]};
        for (int j = 0; j < 3; j++) begin
            free_stop[j] = bus_clock_stop_i && r4[F4_FREE_STOP_LSB + j];
            bg.want[j] = free_en[j] && !power_down_i && !free_stop[j];
        end
        for (int m = 0; m < 6; m++) begin
            // plain bus clocks always stop on software stop
            bg.want[3+m] = r2[F2_PCI_OE_LSB + m] && !power_down_i &&
                           !bus_clock_stop_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            periph_oe_r <= '0;
            cpu_oe_r <= '0;
            disp_oe_r <= 1'b0;
            free_oe_r <= '0;
            pci_oe_r <= '0;
            usb_oe_r <= 1'b0;
            xtal_oe_r <= 1'b0;
            spread_en_r <= 1'b0;
            spread_center_r <= 1'b0;
        end else begin
            periph_oe_r <= p_oe_nxt;
            cpu_oe_r <= cpu_oe_nxt;
            disp_oe_r <= disp_oe_nxt;
            free_oe_r <= free_en;
            pci_oe_r <= r2[F2_PCI_OE_LSB +: 6];
            usb_oe_r <= r1[F1_USB_OE];
            xtal_oe_r <= r1[F1_XTAL_OE];
            spread_en_r <= r1[F1_SPREAD_EN];
            spread_center_r <= r1[F1_SPREAD_CENTER];
        end
    end

    assign rd_data_o = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign periph_run_o = dg.run[6:0];
    assign periph_oe_o = periph_oe_r;
    assign cpu_run_o = dg.run[8:7];
    assign cpu_oe_o = cpu_oe_r;
    assign disp_run_o = dg.run[9];
    assign disp_oe_o = disp_oe_r;
    assign free_run_o = bg.run[2:0];
    assign free_oe_o = free_oe_r;
    assign pci_run_o = bg.run[8:3];
    assign pci_oe_o = pci_oe_r;
    assign usb_oe_o = usb_oe_r;
    assign xtal_oe_o = xtal_oe_r;
    assign spread_en_o = spread_en_r;
    assign spread_center_o = spread_center_r;

    sequence s_pd_low_phase;
        power_down_i && diff_phase_low_i;
    endsequence

    chk_power_defaults: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        !touched_r |-> act_r == RST_BANK)
        else $error("bank left its defaults without a write");

    chk_write_deferred: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        acc.wr_stb && !acc.commit |=> $stable(act_r))
        else $error("write took effect before the transfer ended");

    chk_commit_apply: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        acc.commit |=> act_r == shadow_r && touched_r)
        else $error("commit did not load the active bank");

    chk_periph_oe_off: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> (periph_oe_r & ~$past(r0[7:1])) == 7'h00)
        else $error("disabled peripheral pair still driven");

    chk_cpu_oe_off: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> (cpu_oe_r & ~$past(r1[2:1])) == 2'b00)
        else $error("disabled cpu pair still driven");

    chk_disp_pd_hiz: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        power_down_i && r4[6] && !dg.run[9] |=> !disp_oe_r)
        else $error("display pair driven in power-down high impedance");

    chk_spread_follow: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> spread_en_r == $past(r1[0]) &&
                 spread_center_r == $past(r1[3]))
        else $error("spread outputs do not follow their bits");

    chk_pd_halt_low: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        s_pd_low_phase |=> dg.run == '0)
        else $error("differential clocks still run in power-down");

    chk_stop_hiz: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        bus_clock_stop_i && r5[7] && r3[1] && !dg.run[0] |=> !periph_oe_r[1])
        else $error("stopped pair 1 not released to high impedance");

    chk_free_stop: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        bus_clock_stop_i && r4[3] && bus_phase_low_i |=> !free_run_o[0])
        else $error("stoppable free-running clock kept running");

endmodule

`default_nettype wire

// File: verification/cocr_host.sv
// host model: drives the byte port as the serial controller would
// assumes it changes its lines at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module cocr_host (
    input wire logic clk_i,           // system clock
    input wire logic [7:0] rd_data_i, // read byte
    input wire logic rd_valid_i,      // read strobe
    output logic byte_valid_o,        // byte present
    output logic cmd_first_o,         // command byte flag
    output logic [7:0] byte_o,        // written byte
    output logic rd_req_o,            // read request
    output logic xfer_end_o           // stop seen
);
    initial begin
        byte_valid_o = 1'b0;
        cmd_first_o = 1'b0;
        byte_o = 8'h5a;
        rd_req_o = 1'b0;
        xfer_end_o = 1'b0;
    end
    task automatic start(input logic [7:0] cmd);
        @(negedge clk_i);
        byte_valid_o = 1'b1;
        cmd_first_o = 1'b1;
        byte_o = cmd;
    endtask
    // released data lines show the inverse, never a stale value
    task automatic stop();
        @(negedge clk_i);
        byte_valid_o = 1'b0;
        rd_req_o = 1'b0;
        xfer_end_o = 1'b1;
        byte_o = ~byte_o;
        @(negedge clk_i);
        xfer_end_o = 1'b0;
    endtask
    // byte mode command; callers keep reserved bits fixed
    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        start({1'b1, ofs});
        @(negedge clk_i);
        cmd_first_o = 1'b0;
        byte_o = d;
        stop();
    endtask
    // block write: count byte first, then data from offset 0
    task automatic wr_blk(input logic [7:0] n, input logic [7:0] d);
        start(8'h00);
        @(negedge clk_i);
        cmd_first_o = 1'b0;
        byte_o = n;
        @(negedge clk_i);
        byte_o = d;
        stop();
    endtask
    task automatic get(output logic [7:0] d);
        @(negedge clk_i);
        byte_valid_o = 1'b0;
        cmd_first_o = 1'b0;
        byte_o = ~byte_o;
        rd_req_o = 1'b1;
        @(negedge clk_i);
        rd_req_o = 1'b0;
        d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [7:0] a,
                      output logic [7:0] b);
        start(cmd);
        get(a);
        get(b);
        stop();
    endtask
endmodule
`default_nettype wire

// File: verification/clock_output_control_regs_tb.sv
// self-checking bench for the clock output control bank
// assumes the host model as the only register master
`timescale 1ns/1ps
`default_nettype none
module clock_output_control_regs_tb;
    logic clk = 1'b0, rst_n = 1'b0, stp = 1'b0, pd = 1'b0, ph = 1'b0;
    logic dbg = 1'b0;
    logic bv, cf, rq, xe, rv, den, dru, usb, xt, sen, sc;
    logic [7:0] by, rdd, a, b;
    logic [7:1] pru, poe;
    logic [1:0] cru, coe;
    logic [2:0] fru, foe;
    logic [5:0] qru, qoe;
    int err_total = 0, check_count = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    // phases alternate so run gates see low windows regularly
    always @(negedge clk) ph <= ~ph;
    cocr_host host_u (.clk_i(clk), .rd_data_i(rdd), .rd_valid_i(rv),
        .byte_valid_o(bv), .cmd_first_o(cf), .byte_o(by), .rd_req_o(rq),
        .xfer_end_o(xe));
    cocr_top dut_u (.clk_i(clk), .arst_n_i(rst_n), .byte_valid_i(bv),
        .cmd_first_i(cf), .byte_i(by), .rd_req_i(rq), .xfer_end_i(xe),
        .bus_clock_stop_i(stp), .power_down_i(pd), .debug_port_mode_i(dbg),
        .diff_phase_low_i(ph), .bus_phase_low_i(~ph), .rd_data_o(rdd),
        .rd_valid_o(rv), .periph_run_o(pru), .periph_oe_o(poe),
        .cpu_run_o(cru), .cpu_oe_o(coe), .disp_run_o(dru), .disp_oe_o(den),
        .free_run_o(fru), .free_oe_o(foe), .pci_run_o(qru), .pci_oe_o(qoe),
        .usb_oe_o(usb), .xtal_oe_o(xt), .spread_en_o(sen),
        .spread_center_o(sc));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic idle();
        repeat (6) @(negedge clk);
    endtask
    task automatic t_defaults();
        host_u.rd(8'h80, a, b);
        chk(a, 8'hff);
        chk(b, 8'hf6);
        host_u.rd(8'h82, a, b);
        chk(a, 8'hff);
        chk(b, 8'h00);
        host_u.rd(8'h84, a, b);
        chk(a, 8'h07);
        chk(b, 8'h00);
        chk({1'b0, poe}, 8'h7f);
        chk({1'b0, coe, den, usb, xt, sen, sc}, 8'h7c);
        chk({2'b0, qoe}, 8'h3f);
        $display("defaults done");
    endtask
    task automatic t_enables();
        host_u.wr(7'h01, 8'h0f);
        idle();
        chk({1'b0, coe, den, usb, xt, sen, sc}, 8'h63);
        chk({5'b0, foe}, 8'h06);
        host_u.wr(7'h02, 8'h03);
        host_u.wr(7'h00, 8'h55);
        idle();
        chk({2'b0, qoe}, 8'h00);
        chk({1'b0, poe}, 8'h2a);
        host_u.wr(7'h00, 8'hff);
        host_u.wr(7'h01, 8'hf6);
        host_u.wr(7'h02, 8'hff);
        idle();
        chk({1'b0, coe, den, usb, xt, sen, sc}, 8'h7c);
        $display("enables done");
    endtask
    task automatic t_block();
        host_u.rd(8'h00, a, b);
        chk(a, 8'h06);
        chk(b, 8'hff);
        host_u.wr_blk(8'h01, 8'h54);
        host_u.rd(8'h80, a, b);
        chk(a, 8'h55);
        chk(b, 8'hf6);
        host_u.wr(7'h00, 8'hff);
        $display("block read done");
    endtask
    task automatic t_stop();
        host_u.wr(7'h03, 8'h02);
        host_u.wr(7'h04, 8'h0f);
        host_u.wr(7'h05, 8'h80);
        stp = 1'b1;
        idle();
        chk({1'b0, pru}, 8'h7e);
        chk({1'b0, poe}, 8'h7e);
        chk({5'b0, fru}, 8'h06);
        chk({2'b0, qru}, 8'h00);
        stp = 1'b0;
        idle();
        chk({pru, poe[1]}, 8'hff);
        host_u.wr(7'h03, 8'h00);
        host_u.wr(7'h04, 8'h47);
        host_u.wr(7'h05, 8'h09);
        pd = 1'b1;
        idle();
        chk({1'b0, poe}, 8'h00);
        chk({6'b0, coe}, 8'h02);
        chk({6'b0, den, dru}, 8'h00);
        chk({1'b0, pru}, 8'h00);
        chk({qoe, cru}, 8'hfc);
        pd = 1'b0;
        idle();
        chk({5'b0, coe, den}, 8'h07);
        $display("stop and power-down done");
    endtask
    task automatic t_debug();
        dbg = 1'b1;
        host_u.wr(7'h03, 8'h80);
        host_u.wr(7'h05, 8'h84);
        stp = 1'b1;
        idle();
        chk({1'b0, pru}, 8'h7f);
        chk({1'b0, poe}, 8'h7f);
        stp = 1'b0;
        pd = 1'b1;
        idle();
        chk({1'b0, poe}, 8'h3f);
        pd = 1'b0;
        dbg = 1'b0;
        idle();
        $display("debug port pair done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        t_defaults();
        t_enables();
        t_block();
        t_stop();
        t_debug();
        close_out();
    end
endmodule
`default_nettype wire
